// ---- vowcd_top.sv ----
// Purpose: Second video window selection: field enable, frame decimation,
//          line dropping, horizontal scaling and crop, behind an APB slave.
// Assumes: Pixel stream is synchronous to clk_in; line_start_in marks the
//          first pixel of a line, field_start_in is a pulse between fields.
// Notes: Downscaling only; each kept pixel is a chosen input pixel.
//
// Notes on behaviour
// - With decimation on, only the programmed frame count per 3000 frames passes.
// - Field code: 11 off, 10 odd only, 01 even only, 00 both fields.
// - Fewer output lines than input lines: drop whole lines, no filtering.
// - Window start is an 11-bit position on the scaled line.
// - A nonzero window start crops that many scaled pixels on the left.
// - Window passes an 11-bit count of scaled pixels from the start.
// - Each full input line is scaled to the programmed active pixel count when it is as long as the previous line, or 640 pixels after reset.
// - Input line count above the standard's maximum is clamped automatically.
//
// The APB slave port was decided locally.

module vowcd_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic std_625_in,
    input wire logic field_start_in,
    input wire logic field_odd_in,
    input wire logic pix_valid_in,
    input wire logic line_start_in,
    input wire logic [15:0] pix_data_in,
    output logic pix_ready_out,
    output logic vid_valid_out,
    input wire logic vid_ready_in,
    output logic [15:0] vid_data_out,
    output logic vid_line_start_out,
    output logic vid_field_start_out
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // One step of a rate accumulator: returns {emit, new accumulator}.
    function automatic logic [13:0] dda_step(input logic [12:0] acc,
                                             input logic [12:0] add,
                                             input logic [12:0] lim);
        logic [12:0] sum;
        sum = acc + add;
        if (sum >= lim) begin
            dda_step = {1'b1, 13'(sum - lim)};
        end else begin
            dda_step = {1'b0, sum};
        end
    endfunction

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == vowcd_pkg::ADDR_IN_LINES) || (a == vowcd_pkg::ADDR_OUT_LINES) ||
                   (a == vowcd_pkg::ADDR_HSTART) || (a == vowcd_pkg::ADDR_HLEN) ||
                   (a == vowcd_pkg::ADDR_NPIX) || (a == vowcd_pkg::ADDR_KEPT) ||
                   (a == vowcd_pkg::ADDR_STATUS);
    endfunction

    // ****************************************************************
    // Registers and APB slave
    // ****************************************************************

    logic [11:0] inl_q;
    logic [11:0] outl_q;
    logic [11:0] hst_q;
    logic [11:0] hlen_q;
    logic [11:0] npix_q;
    logic [11:0] kept_q;
    logic [31:0] rdata_q;
    logic err_q;
    logic [11:0] rd_mux;
    logic [11:0] status;
    logic wr_en;
    vowcd_pkg::vowcd_fstate_t fstate_q;
    logic frame_keep_q;
    logic [8:0] vout_q;

    assign wr_en = psel_in && penable_in && pwrite_in && addr_hit(paddr_in) &&
                   (paddr_in != vowcd_pkg::ADDR_STATUS);
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && err_q;
    assign prdata_out = rdata_q;
    assign status = {vout_q, frame_keep_q, fstate_q};

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            inl_q <= vowcd_pkg::RST_IN_LINES;
            outl_q <= vowcd_pkg::RST_OUT_LINES;
            hst_q <= vowcd_pkg::RST_HSTART;
            hlen_q <= vowcd_pkg::RST_HLEN;
            npix_q <= vowcd_pkg::RST_NPIX;
            kept_q <= vowcd_pkg::RST_KEPT;
        end else if (wr_en) begin
            if (paddr_in == vowcd_pkg::ADDR_IN_LINES) begin
                inl_q <= pwdata_in[11:0];
            end else if (paddr_in == vowcd_pkg::ADDR_OUT_LINES) begin
                outl_q <= pwdata_in[11:0];
            end else if (paddr_in == vowcd_pkg::ADDR_HSTART) begin
                hst_q <= pwdata_in[11:0];
            end else if (paddr_in == vowcd_pkg::ADDR_HLEN) begin
                hlen_q <= pwdata_in[11:0];
            end else if (paddr_in == vowcd_pkg::ADDR_NPIX) begin
                npix_q <= pwdata_in[11:0];
            end else begin
                kept_q <= pwdata_in[11:0];
            end
        end
    end

    always_comb begin
        if (paddr_in == vowcd_pkg::ADDR_IN_LINES) begin
            rd_mux = inl_q;
        end else if (paddr_in == vowcd_pkg::ADDR_OUT_LINES) begin
            rd_mux = outl_q;
        end else if (paddr_in == vowcd_pkg::ADDR_HSTART) begin
            rd_mux = hst_q;
        end else if (paddr_in == vowcd_pkg::ADDR_HLEN) begin
            rd_mux = hlen_q;
        end else if (paddr_in == vowcd_pkg::ADDR_NPIX) begin
            rd_mux = npix_q;
        end else if (paddr_in == vowcd_pkg::ADDR_KEPT) begin
            rd_mux = kept_q;
        end else if (paddr_in == vowcd_pkg::ADDR_STATUS) begin
            rd_mux = status;
        end else begin
            rd_mux = 12'h000;
        end
    end

    // Read data is captured in the setup cycle so it leaves a flip-flop.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end else if (psel_in && !penable_in) begin
            rdata_q <= pwrite_in ? 32'h00000000 : {20'h00000, rd_mux};
            err_q <= !addr_hit(paddr_in);
        end
    end

    // ****************************************************************
    // Field and frame selection
    // ****************************************************************

    logic [8:0] in_lines;
    logic [8:0] max_lines;
    logic [8:0] eff_lines;
    logic [8:0] out_lines;
    logic [1:0] fcode;
    logic dec_en;
    logic field_ok;
    logic frame_start;
    logic [11:0] frame_cnt_q;
    logic [11:0] frame_next;
    logic frame_keep_d;

    assign in_lines = inl_q[vowcd_pkg::LINES_MSB:0];
    assign out_lines = outl_q[vowcd_pkg::LINES_MSB:0];
    assign dec_en = inl_q[vowcd_pkg::DEC_EN_BIT];
    assign fcode = inl_q[vowcd_pkg::FCODE_LSB +: 2];
    assign max_lines = std_625_in ? vowcd_pkg::MAX_LINES_625 : vowcd_pkg::MAX_LINES_525;
    assign eff_lines = (in_lines > max_lines) ? max_lines : in_lines;
    assign frame_start = field_start_in && field_odd_in;
    assign frame_next = (frame_cnt_q == vowcd_pkg::FRAME_CNT_RST) ? 12'h000 :
                        frame_cnt_q + 12'h001;
    assign frame_keep_d = frame_start ? (!dec_en || (frame_next < kept_q)) :
                          frame_keep_q;

    always_comb begin
        case (fcode)
            vowcd_pkg::FC_OFF: field_ok = 1'b0;
            vowcd_pkg::FC_ODD: field_ok = field_odd_in;
            vowcd_pkg::FC_EVEN: field_ok = !field_odd_in;
            default: field_ok = 1'b1;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_cnt_q <= vowcd_pkg::FRAME_CNT_RST;
            frame_keep_q <= 1'b1;
        end else if (frame_start) begin
            frame_cnt_q <= frame_next;
            frame_keep_q <= frame_keep_d;
        end
    end

    // The field code and frame keep are sampled at each field start, so a field is never split.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fstate_q <= vowcd_pkg::FS_WAIT;
        end else if (field_start_in) begin
            case (fstate_q)
                default: fstate_q <= (field_ok && frame_keep_d) ? vowcd_pkg::FS_ON :
                                     vowcd_pkg::FS_OFF;
            endcase
        end
    end

    // ****************************************************************
    // Line dropping and horizontal scaling
    // ****************************************************************

    logic take;
    logic push_want;
    logic push;
    logic fifo_ready;
    logic ls;
    logic [8:0] vidx_q;
    logic [8:0] accv_q;
    logic line_keep_q;
    logic [13:0] vd;
    logic v_in_ok;
    logic vkeep_now;
    logic [11:0] cnt_q;
    logic [11:0] in_len_q;
    logic [11:0] len_cur;
    logic [11:0] acc_h_q;
    logic [11:0] acc_base;
    logic [13:0] hd;
    logic [10:0] sx_q;
    logic [10:0] sx_cur;
    logic [10:0] npix;
    logic [10:0] hstart;
    logic [11:0] hend;
    logic h_emit;
    logic in_win;
    logic fs_mark_q;
    logic ln_mark_q;

    assign ls = pix_valid_in && line_start_in;
    assign npix = npix_q[vowcd_pkg::PIX_MSB:0];
    assign hstart = hst_q[vowcd_pkg::PIX_MSB:0];
    assign hend = {1'b0, hstart} + {1'b0, hlen_q[vowcd_pkg::PIX_MSB:0]};

    // Vertical: one accumulator step per input line inside the active range.
    assign v_in_ok = vidx_q < eff_lines;
    assign vd = dda_step({4'h0, accv_q}, {4'h0, out_lines}, {4'h0, eff_lines});
    assign vkeep_now = ls ? (v_in_ok && vd[13] && (vout_q < out_lines)) :
                       line_keep_q;

    // Horizontal: the previous line's length is the scaling reference.
    assign len_cur = (ls && (cnt_q != 12'h000)) ? cnt_q : in_len_q;
    assign acc_base = ls ? 12'h000 : acc_h_q;
    assign sx_cur = ls ? 11'h000 : sx_q;
    assign hd = dda_step({1'b0, acc_base}, {2'b00, npix}, {1'b0, len_cur});
    assign h_emit = hd[13] && (sx_cur < npix);
    assign in_win = ({1'b0, sx_cur} < hend) && (sx_cur >= hstart);

    assign push_want = pix_valid_in && (fstate_q == vowcd_pkg::FS_ON) && vkeep_now &&
                       h_emit && in_win;
    assign push = push_want && fifo_ready;
    assign pix_ready_out = !push_want || fifo_ready;
    assign take = pix_valid_in && pix_ready_out;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            vidx_q <= 9'h000;
            accv_q <= 9'h000;
            vout_q <= 9'h000;
            line_keep_q <= 1'b0;
        end else if (field_start_in) begin
            vidx_q <= 9'h000;
            accv_q <= 9'h000;
            vout_q <= 9'h000;
            line_keep_q <= 1'b0;
        end else if (take && ls) begin
            vidx_q <= (vidx_q == 9'h1FF) ? vidx_q : vidx_q + 9'h001;
            line_keep_q <= vkeep_now;
            if (v_in_ok) begin
                accv_q <= vd[8:0];
            end
            if (vkeep_now) begin
                vout_q <= vout_q + 9'h001;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q <= 12'h000;
            in_len_q <= vowcd_pkg::RST_NPIX;
            acc_h_q <= 12'h000;
            sx_q <= 11'h000;
        end else if (take) begin
            cnt_q <= ls ? 12'h001 : ((cnt_q == 12'hFFF) ? cnt_q : cnt_q + 12'h001);
            if (ls) begin
                in_len_q <= len_cur;
            end
            acc_h_q <= hd[11:0];
            sx_q <= h_emit ? sx_cur + 11'h001 : sx_cur;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            fs_mark_q <= 1'b0;
        end else if (field_start_in) begin
            fs_mark_q <= 1'b1;
        end else if (push) begin
            fs_mark_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ln_mark_q <= 1'b0;
        end else if (take && ls) begin
            ln_mark_q <= !push;
        end else if (push) begin
            ln_mark_q <= 1'b0;
        end
    end

    // ****************************************************************
    // Output buffer
    // ****************************************************************

    logic [17:0] fifo_out;

    // The buffer absorbs short downstream stalls; a long stall halts the input.
    vowcd_fifo #(
        .WIDTH(vowcd_pkg::FIFO_W),
        .DEPTH(vowcd_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_valid_in(push_want),
        .wr_ready_out(fifo_ready),
        .wr_data_in({fs_mark_q, ls | ln_mark_q, pix_data_in}),
        .rd_valid_out(vid_valid_out),
        .rd_ready_in(vid_ready_in),
        .rd_data_out(fifo_out)
    );

    assign vid_data_out = fifo_out[15:0];
    assign vid_line_start_out = fifo_out[16];
    assign vid_field_start_out = fifo_out[17];

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_field_begin(logic [1:0] code);
        field_start_in && (fcode == code);
    endsequence

    sequence s_rd_setup(logic [11:0] a);
        psel_in && !penable_in && !pwrite_in && (paddr_in == a);
    endsequence

    sequence s_access;
        psel_in && penable_in;
    endsequence

    logic wrote_q;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wrote_q <= 1'b0;
        end else if (wr_en) begin
            wrote_q <= 1'b1;
        end
    end

    a_field_off: assert property (s_field_begin(vowcd_pkg::FC_OFF) |=>
        fstate_q == vowcd_pkg::FS_OFF) else $error("Disabled window went active.");
    a_odd_only: assert property (s_field_begin(vowcd_pkg::FC_ODD) && !field_odd_in |=>
        fstate_q == vowcd_pkg::FS_OFF) else $error("Odd-only window active in even field.");
    a_decim_skip: assert property (frame_start && dec_en && (frame_next >= kept_q) |=>
        fstate_q != vowcd_pkg::FS_ON) else $error("Decimated frame was output.");
    a_frame_wrap: assert property (frame_start && (frame_cnt_q == vowcd_pkg::FRAME_CNT_RST)
        |=> frame_cnt_q == 12'h000) else $error("Frame interval did not wrap.");
    a_crop_left: assert property (push |-> sx_cur >= hstart)
        else $error("Pixel left of window start was output.");
    a_crop_len: assert property (push |-> {1'b0, sx_cur} < hend)
        else $error("Pixel beyond window length was output.");
    a_line_drop: assert property (push |-> vkeep_now && (vout_q <= out_lines))
        else $error("Pixel of a dropped line was output.");
    a_off_silent: assert property (fstate_q != vowcd_pkg::FS_ON |-> !push)
        else $error("Output while window inactive.");
    a_scaled_cap: assert property (take && h_emit |=> sx_q <= npix)
        else $error("Scaled line exceeded pixel count.");
    a_line_clamp: assert property (eff_lines <= max_lines && eff_lines <= in_lines)
        else $error("Input line count not clamped.");
    a_reset_vals: assert property (!wrote_q |-> outl_q == vowcd_pkg::RST_OUT_LINES &&
        hlen_q == vowcd_pkg::RST_HLEN && npix_q == vowcd_pkg::RST_NPIX)
        else $error("Window registers left reset values unwritten.");
    a_read_npix: assert property (s_rd_setup(vowcd_pkg::ADDR_NPIX) ##1 s_access |->
        prdata_out == {20'h00000, npix_q}) else $error("Pixel count read back wrong.");

endmodule

// ---- vowcd_pkg.sv ----
// Purpose: Shared constants for the second video window crop and decimation block.
// Assumes: Registers are twelve bits wide and sit one per 32-bit APB word.
// Notes: Byte address of each register is four times its index.

// ****************************************************************
// Package
// ****************************************************************
package vowcd_pkg;

    localparam int REG_W = 12;
    localparam int PIX_W = 16;
    localparam int FIFO_W = 18;
    localparam int FIFO_DEPTH = 16;

    // Register indexes; the byte address is the index times four.
    localparam logic [9:0] IDX_IN_LINES = 10'h12B;
    localparam logic [9:0] IDX_OUT_LINES = 10'h12C;
    localparam logic [9:0] IDX_HSTART = 10'h12D;
    localparam logic [9:0] IDX_HLEN = 10'h12E;
    localparam logic [9:0] IDX_NPIX = 10'h12F;
    localparam logic [9:0] IDX_KEPT = 10'h157;
    localparam logic [9:0] IDX_STATUS = 10'h160;

    localparam logic [11:0] ADDR_IN_LINES = {IDX_IN_LINES, 2'b00};
    localparam logic [11:0] ADDR_OUT_LINES = {IDX_OUT_LINES, 2'b00};
    localparam logic [11:0] ADDR_HSTART = {IDX_HSTART, 2'b00};
    localparam logic [11:0] ADDR_HLEN = {IDX_HLEN, 2'b00};
    localparam logic [11:0] ADDR_NPIX = {IDX_NPIX, 2'b00};
    localparam logic [11:0] ADDR_KEPT = {IDX_KEPT, 2'b00};
    localparam logic [11:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

    // Field positions.
    localparam int LINES_MSB = 8;
    localparam int PIX_MSB = 10;
    localparam int DEC_EN_BIT = 9;
    localparam int FCODE_LSB = 10;

    // Field enable codes.
    localparam logic [1:0] FC_BOTH = 2'b00;
    localparam logic [1:0] FC_EVEN = 2'b01;
    localparam logic [1:0] FC_ODD = 2'b10;
    localparam logic [1:0] FC_OFF = 2'b11;

    // Decimation interval in frames.
    localparam logic [11:0] DEC_INTERVAL = 12'hBB8;
    localparam logic [11:0] FRAME_CNT_RST = DEC_INTERVAL - 12'h001;

    // Largest active line count per field for each line standard.
    localparam logic [8:0] MAX_LINES_625 = 9'h120;
    localparam logic [8:0] MAX_LINES_525 = 9'h0F0;

    // Reset values.
    localparam logic [11:0] RST_IN_LINES = 12'h1F4;
    localparam logic [11:0] RST_OUT_LINES = 12'h0F0;
    localparam logic [11:0] RST_HSTART = 12'h000;
    localparam logic [11:0] RST_HLEN = 12'h280;
    localparam logic [11:0] RST_NPIX = 12'h280;
    localparam logic [11:0] RST_KEPT = DEC_INTERVAL;

    typedef enum logic [1:0] {
        FS_WAIT = 2'b00,
        FS_ON = 2'b01,
        FS_OFF = 2'b11
    } vowcd_fstate_t;

endpackage

// ---- vowcd_fifo.sv ----
// Purpose: Small synchronous FIFO with valid and ready on both sides.
// Assumes: One clock; write and read may happen in the same cycle.
// Notes: Full and empty come from a word count, so the FIFO fills completely.

module vowcd_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic rd_valid_out,
    input wire logic rd_ready_in,
    output logic [WIDTH-1:0] rd_data_out
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0] count_q;
    logic do_wr;
    logic do_rd;

    assign wr_ready_out = (count_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (count_q != '0);
    assign rd_data_out = mem_q[rd_ptr_q];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;

    always_ff @(posedge clk_in) begin
        if (do_wr) begin
            mem_q[wr_ptr_q] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
            end
            if (do_rd) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
            end
            if (do_wr && !do_rd) begin
                count_q <= count_q + (AW+1)'(1);
            end else if (do_rd && !do_wr) begin
                count_q <= count_q - (AW+1)'(1);
            end
        end
    end

endmodule

// ---- vowcd_sink.sv ----
// Purpose: Downstream video sink model that takes the window output.
// Assumes: A pixel is taken at each edge with valid and ready both high.
// Notes: Slow mode gives ready one cycle in four, so the FIFO fills and stalls input.

// ****************************************************************
// Sink model
// ****************************************************************
module vowcd_sink (
    input wire logic clk_in,
    input wire logic clr_in,
    input wire logic slow_in,
    input wire logic vid_valid_in,
    output logic vid_ready_out,
    input wire logic [15:0] vid_data_in,
    input wire logic vid_line_start_in,
    input wire logic vid_field_start_in,
    output int pix_cnt_out,
    output int line_cnt_out,
    output int field_cnt_out,
    output logic [15:0] first_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ph_q = 2'h0;
    assign vid_ready_out = !slow_in || ph_q == 2'h0;
    always_ff @(posedge clk_in) begin
        ph_q <= ph_q + 2'h1;
        if (clr_in) begin
            pix_cnt_out <= 0;
            line_cnt_out <= 0;
            field_cnt_out <= 0;
        end else if (vid_valid_in && vid_ready_out) begin
            pix_cnt_out <= pix_cnt_out + 1;
            if (vid_field_start_in) begin
                field_cnt_out <= field_cnt_out + 1;
            end
            if (vid_line_start_in) begin
                line_cnt_out <= line_cnt_out + 1;
                first_data_out <= vid_data_in;
            end
        end
    end
endmodule

// ---- vowcd_top_test.sv ----
// Purpose: Self-checking bench for the window crop and decimation block.
// Assumes: Every input line carries 64 pixels; the sink model pops the output.
// Notes: Counts are cleared at each field start and compared after the FIFO drains.

// ****************************************************************
// Bench
// ****************************************************************
module vowcd_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, std_625_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, pix_ready_out, vid_valid_out, vid_ready_in, err;
    logic field_start_in = 1'b0, field_odd_in = 1'b0, pix_valid_in = 1'b0;
    logic line_start_in = 1'b0, vid_line_start_out, vid_field_start_out;
    logic [15:0] pix_data_in = 16'h0000, vid_data_out, first_data;
    logic clr = 1'b1, slow = 1'b0;
    int pix_cnt, line_cnt, field_cnt, n_fail = 0, checks = 0;
    always #5 clk_in = ~clk_in;
    vowcd_top DUT (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .std_625_in, .field_start_in,
        .field_odd_in, .pix_valid_in, .line_start_in, .pix_data_in, .pix_ready_out,
        .vid_valid_out, .vid_ready_in, .vid_data_out, .vid_line_start_out,
        .vid_field_start_out);
    vowcd_sink SINK (.clk_in, .clr_in(clr), .slow_in(slow), .vid_valid_in(vid_valid_out),
        .vid_ready_out(vid_ready_in), .vid_data_in(vid_data_out),
        .vid_line_start_in(vid_line_start_out), .vid_field_start_in(vid_field_start_out),
        .pix_cnt_out(pix_cnt), .line_cnt_out(line_cnt), .field_cnt_out(field_cnt),
        .first_data_out(first_data));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Every wait is bounded; running out counts as a mismatch and ends the run.
    task automatic tick_until(input bit done, input int n);
        if (!done && n >= 2000) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 2000);
        tick_until(pready_out === 1'b1, n);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask
    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask
    task automatic field(input logic odd, input int nl);
        int n;
        clr <= 1'b1;
        field_start_in <= 1'b1;
        field_odd_in <= odd;
        @(posedge clk_in);
        clr <= 1'b0;
        field_start_in <= 1'b0;
        for (int l = 0; l < nl; l++) begin
            for (int p = 0; p < 64; p++) begin
                pix_valid_in <= 1'b1;
                line_start_in <= (p == 0);
                pix_data_in <= {l[7:0], p[7:0]};
                n = 0;
                do begin
                    @(posedge clk_in);
                    n++;
                end while (pix_ready_out !== 1'b1 && n < 2000);
                tick_until(pix_ready_out === 1'b1, n);
            end
        end
        pix_valid_in <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (vid_valid_out !== 1'b0 && n < 2000);
        tick_until(vid_valid_out === 1'b0, n);
    endtask
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rdchk("out_lines", vowcd_pkg::ADDR_OUT_LINES, 32'h0F0);
        rdchk("hstart", vowcd_pkg::ADDR_HSTART, 32'h000);
        rdchk("hlen", vowcd_pkg::ADDR_HLEN, 32'h280);
        rdchk("npix", vowcd_pkg::ADDR_NPIX, 32'h280);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("unmapped error", err, 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test registers done");
        apb(1'b1, vowcd_pkg::ADDR_IN_LINES, 32'h004);
        apb(1'b1, vowcd_pkg::ADDR_OUT_LINES, 32'h004);
        apb(1'b1, vowcd_pkg::ADDR_HSTART, 32'h004);
        apb(1'b1, vowcd_pkg::ADDR_HLEN, 32'h008);
        field(1'b1, 4);
        chk("crop pixels", pix_cnt, 32'd32);
        chk("crop lines", line_cnt, 32'd4);
        chk("crop first", first_data[7:0], 32'h04);
        chk("field marks", field_cnt, 32'd1);
        $display("test crop done");
        slow <= 1'b1;
        apb(1'b1, vowcd_pkg::ADDR_OUT_LINES, 32'h002);
        apb(1'b1, vowcd_pkg::ADDR_NPIX, 32'h020);
        apb(1'b1, vowcd_pkg::ADDR_HSTART, 32'h000);
        apb(1'b1, vowcd_pkg::ADDR_HLEN, 32'h020);
        field(1'b1, 4);
        chk("drop lines", line_cnt, 32'd2);
        chk("scaled pixels", pix_cnt, 32'd64);
        chk("drop first", first_data, 32'h0301);
        $display("test scale and drop done");
        slow <= 1'b0;
        apb(1'b1, vowcd_pkg::ADDR_OUT_LINES, 32'h004);
        for (int c = 0; c < 4; c++) begin
            for (int o = 1; o >= 0; o--) begin
                apb(1'b1, vowcd_pkg::ADDR_IN_LINES, {20'h0, c[1:0], 10'h004});
                field(o[0], 4);
                chk("field lines", line_cnt, (c == 0 || c == (o ? 2 : 1)) ? 4 : 0);
            end
        end
        $display("test field codes done");
        apb(1'b1, vowcd_pkg::ADDR_KEPT, 32'h000);
        apb(1'b1, vowcd_pkg::ADDR_IN_LINES, 32'h204);
        field(1'b1, 4);
        chk("decimated odd", line_cnt, 32'd0);
        field(1'b0, 4);
        chk("decimated even", line_cnt, 32'd0);
        apb(1'b1, vowcd_pkg::ADDR_KEPT, {20'h0, vowcd_pkg::DEC_INTERVAL});
        field(1'b1, 4);
        chk("all frames kept", line_cnt, 32'd4);
        $display("test decimation done");
        apb(1'b1, vowcd_pkg::ADDR_IN_LINES, 32'h1F4);
        apb(1'b1, vowcd_pkg::ADDR_OUT_LINES, 32'h001);
        field(1'b1, 240);
        chk("clamp 525", line_cnt, 32'd1);
        std_625_in <= 1'b1;
        field(1'b1, 240);
        chk("clamp 625", line_cnt, 32'd0);
        $display("test line clamp done");
        end_sim();
    end
endmodule
